/* ram_block_model.sv */
// Behavioural model of the on-chip memory block as one 512 x 32 RAM.
// Assumes both ports get identical control, so port A pins steer it.
`timescale 1ns/10ps
module ram_block_model
  import ram_ctrl_pkg::*;
(
  // Port clock
  input wire logic clk,
  // Shared control
  input wire logic [PADDR_W-1:0] addr,
  input wire logic ce,
  input wire logic we,
  input wire logic orce,
  input wire logic orst,
  // Write data halves
  input wire logic [PORT_W-1:0] wd_a,
  input wire logic [PORT_W-1:0] wd_b,
  // Read data halves
  output logic [PORT_W-1:0] rd_a,
  output logic [PORT_W-1:0] rd_b
);
  logic [WORD_W-1:0] mem [0:511];
  logic [WORD_W-1:0] latch_q = '0;
  logic [WORD_W-1:0] out_q = '0;
  logic junk = 1'b0;

  // Spare bits toggle so that a controller reading them is caught.
  always @(posedge clk) begin
    junk <= ~junk;
    if (ce && we) begin
      mem[addr[PADDR_W-1:PADDR_LSB]] <= {wd_b[16:9], wd_b[7:0], wd_a[16:9], wd_a[7:0]};
    end else if (ce) begin
      latch_q <= mem[addr[PADDR_W-1:PADDR_LSB]];
    end
    if (orst) begin
      out_q <= '0;
    end else if (orce) begin
      out_q <= latch_q;
    end
  end

  assign rd_a = {junk, out_q[15:8], ~junk, out_q[7:0]};
  assign rd_b = {~junk, out_q[31:24], junk, out_q[23:16]};
endmodule : ram_block_model

/* ram_ctrl.sv */
// Operation
// - Both ports run at 32-bit width in one-port mode, 512 words.
// - Both ports use plain write; read pins do not change on writes.
// - Output register is enabled; read data passes one extra stage.
// - Word address drives port address bits 13:5; low five bits high.
// - Address freeze inputs are low, or both driven by one signal.
// - Low data half enters port A at 7:0 and 16:9, zeros at 8, 17.
// - High data half enters port B the same way, zeros at 8 and 17.
// - Depth extension inputs are zero, or both share one signal.
// - Read word is port B 16:9, 7:0 then port A 16:9, 7:0.
// - Read positions 8 and 17 of both ports are left unused.
// - Clock, enables, output reset and write enable shared by both ports.
// - Unnamed settings keep defaults; unlisted inputs may float.
// - Only plain write may be configured at this width.
//
// Controller that drives one on-chip memory block as a 512 x 32 RAM.
// Software reaches it over AXI4-Lite; the memory sits on clk_sys as well.
`timescale 1ns/10ps
module ram_ctrl
  import ram_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory port clocks
  output logic port_a_clock,
  output logic port_b_clock,
  // Memory pins
  output logic [PADDR_W-1:0] port_a_address,
  output logic [PADDR_W-1:0] port_b_address,
  output logic port_a_address_freeze,
  output logic port_b_address_freeze,
  output logic [PORT_W-1:0] port_a_write_data,
  output logic [PORT_W-1:0] port_b_write_data,
  output logic [EXT_W-1:0] port_a_depth_extension,
  output logic [EXT_W-1:0] port_b_depth_extension,
  output logic port_a_input_clock_enable,
  output logic port_b_input_clock_enable,
  output logic port_a_output_reg_enable,
  output logic port_b_output_reg_enable,
  output logic port_a_output_reg_reset,
  output logic port_b_output_reg_reset,
  output logic port_a_write_enable,
  output logic port_b_write_enable,
  input wire logic [PORT_W-1:0] port_a_read_data,
  input wire logic [PORT_W-1:0] port_b_read_data
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_WR_PULSE, ST_RD_WAIT} seq_e;

  seq_e state_reg;
  seq_e state_next;
  logic [31:0] ctrl_reg;
  logic [WADDR_W-1:0] addr_reg;
  logic [WORD_W-1:0] wdata_reg;
  logic [WORD_W-1:0] rdata_reg;
  logic done_reg;
  logic [1:0] wait_reg;
  logic wr_take;
  logic rd_take;
  logic cmd_wr;
  logic cmd_rd;
  logic done_set;
  logic done_clr;
  logic cap_now;
  logic busy;
  logic ce_next;
  logic we_next;
  logic [WORD_W-1:0] read_word;
  logic [WORD_W-1:0] rd_mux;
  logic rd_hit;

  // Byte-lane merge used by the control, address and write data registers.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] upd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = upd[8*i +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  // Address and data are taken together, so neither can be left stranded.
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign rd_take = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_take;
  assign busy = (state_reg != ST_IDLE);

  assign cmd_wr = wr_take && (s_axi_awaddr == OFS_CMD) && s_axi_wstrb[0]
                  && s_axi_wdata[CMD_WRITE_BIT] && !busy;
  assign cmd_rd = wr_take && (s_axi_awaddr == OFS_CMD) && s_axi_wstrb[0]
                  && s_axi_wdata[CMD_READ_BIT] && !s_axi_wdata[CMD_WRITE_BIT] && !busy;
  assign done_clr = wr_take && (s_axi_awaddr == OFS_STATUS) && s_axi_wstrb[0]
                    && s_axi_wdata[STAT_DONE_BIT];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_take) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (s_axi_awaddr <= OFS_RDATA && s_axi_awaddr[1:0] == 2'h0) ?
                     RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Address and data are locked while a cycle runs so the pins stay stable.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (wr_take) begin
      if (s_axi_awaddr == OFS_CTRL) begin
        ctrl_reg <= merge(ctrl_reg, s_axi_wdata, s_axi_wstrb) & 32'h0000_0077;
      end
      if (s_axi_awaddr == OFS_ADDR && !busy) begin
        addr_reg <= WADDR_W'(merge(32'(addr_reg), s_axi_wdata, s_axi_wstrb));
      end
      if (s_axi_awaddr == OFS_WDATA && !busy) begin
        wdata_reg <= merge(wdata_reg, s_axi_wdata, s_axi_wstrb);
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFS_CTRL: rd_mux = ctrl_reg;
      OFS_ADDR: rd_mux = 32'(addr_reg);
      OFS_WDATA: rd_mux = wdata_reg;
      OFS_CMD: rd_mux = 32'h0;
      OFS_STATUS: rd_mux = {30'h0, done_reg, busy};
      OFS_RDATA: rd_mux = rdata_reg;
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  // The write pulse is one cycle; plain write leaves the read pins alone.
  always_comb begin
    state_next = state_reg;
    ce_next = 1'b0;
    we_next = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        if (cmd_wr) begin
          state_next = ST_WR_PULSE;
          ce_next = 1'b1;
          we_next = 1'b1;
        end else if (cmd_rd) begin
          state_next = ST_RD_WAIT;
          ce_next = 1'b1;
        end
      end
      ST_WR_PULSE: state_next = ST_IDLE;
      ST_RD_WAIT: begin
        if (cap_now) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reads wait out the address stage plus the output register stage.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= '0;
    end else if (state_reg == ST_RD_WAIT) begin
      wait_reg <= wait_reg + 2'd1;
    end else begin
      wait_reg <= '0;
    end
  end

  assign cap_now = (state_reg == ST_RD_WAIT) && (wait_reg == READ_LAT_CYCLES);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= '0;
    end else if (cap_now) begin
      rdata_reg <= read_word;
    end
  end

  // A completion in the same cycle as a clear keeps the flag set.
  assign done_set = cap_now || (state_reg == ST_WR_PULSE);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else if (done_set) begin
      done_reg <= 1'b1;
    end else if (done_clr) begin
      done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Memory pins
  // ----------------------------------------------------------------
  // Width, port and write modes are fixed; all else keeps defaults.
  // If software clears the output enable, reads return stale data.
  assign port_a_clock = clk_sys;
  assign port_b_clock = clk_sys;

  ram_pin_map u_map (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .word_addr_next(addr_reg),
    .wdata_next(wdata_reg),
    .ce_next(ce_next),
    .we_next(we_next),
    .orce_next(ctrl_reg[CTRL_ORCE_BIT]),
    .orst_next(ctrl_reg[CTRL_ORST_BIT]),
    .freeze_next(ctrl_reg[CTRL_FREEZE_BIT]),
    .ext_next(ctrl_reg[CTRL_EXT_LSB +: EXT_W]),
    .port_a_address(port_a_address),
    .port_b_address(port_b_address),
    .port_a_address_freeze(port_a_address_freeze),
    .port_b_address_freeze(port_b_address_freeze),
    .port_a_write_data(port_a_write_data),
    .port_b_write_data(port_b_write_data),
    .port_a_depth_extension(port_a_depth_extension),
    .port_b_depth_extension(port_b_depth_extension),
    .port_a_input_clock_enable(port_a_input_clock_enable),
    .port_b_input_clock_enable(port_b_input_clock_enable),
    .port_a_output_reg_enable(port_a_output_reg_enable),
    .port_b_output_reg_enable(port_b_output_reg_enable),
    .port_a_output_reg_reset(port_a_output_reg_reset),
    .port_b_output_reg_reset(port_b_output_reg_reset),
    .port_a_write_enable(port_a_write_enable),
    .port_b_write_enable(port_b_write_enable),
    .port_a_read_data(port_a_read_data),
    .port_b_read_data(port_b_read_data),
    .read_word(read_word)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence rd_issue;
    port_a_input_clock_enable && !port_a_write_enable;
  endsequence

  sequence rd_capture;
    cap_now ##1 (rdata_reg == $past(read_word)) && done_reg;
  endsequence

  a_addr_low_ones: assert property (port_a_address[4:0] == PADDR_LOW_FILL)
    else $error("port address low bits not all ones");
  a_addr_ports_same: assert property ($rose(port_a_input_clock_enable) |->
      port_a_address == port_b_address && port_a_address[13:5] == addr_reg)
    else $error("port addresses differ from word address");
  a_freeze_shared: assert property (port_a_address_freeze == port_b_address_freeze
      && port_a_address_freeze == $past(ctrl_reg[CTRL_FREEZE_BIT]))
    else $error("address freeze pins not shared");
  a_low_half_pack: assert property (port_a_write_enable |->
      port_a_write_data == {1'b0, wdata_reg[15:8], 1'b0, wdata_reg[7:0]})
    else $error("port A write data misplaced");
  a_high_half_pack: assert property (port_b_write_enable |->
      port_b_write_data == {1'b0, wdata_reg[31:24], 1'b0, wdata_reg[23:16]})
    else $error("port B write data misplaced");
  a_ext_shared: assert property (port_a_depth_extension == port_b_depth_extension)
    else $error("depth extension pins differ");
  a_ctrl_shared: assert property (port_a_input_clock_enable == port_b_input_clock_enable
      && port_a_write_enable == port_b_write_enable
      && port_a_output_reg_enable == port_b_output_reg_enable
      && port_a_output_reg_reset == port_b_output_reg_reset)
    else $error("shared control pins differ");
  a_write_one_pulse: assert property ($rose(port_a_write_enable) |->
      port_a_input_clock_enable ##1 !port_a_write_enable && !port_a_input_clock_enable)
    else $error("write pulse not one cycle");
  a_read_latency: assert property (rd_issue |-> ##2 rd_capture)
    else $error("read data not captured two cycles after address");

endmodule : ram_ctrl

/* ram_ctrl_pkg.sv */
// Constants shared by the memory controller and its pin mapper.
// Assumes one clock at 40 MHz and a 32-bit AXI4-Lite register port.
package ram_ctrl_pkg;

  // ----------------------------------------------------------------
  // Memory block geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int PORT_W = 18;
  localparam int WADDR_W = 9;
  localparam int PADDR_W = 14;
  localparam int PADDR_LSB = 5;
  localparam int EXT_W = 3;
  localparam logic [4:0] PADDR_LOW_FILL = 5'h1f;
  localparam logic [2:0] EXT_UNUSED = 3'h0;

  // Write mode of both ports; only plain write is legal at this width.
  typedef enum {plain_write, write_through_read, read_old_then_write} wmode_e;
  localparam wmode_e PORT_WRITE_MODE = plain_write;
  localparam bit ONE_PORT_MODE = 1'b1;
  localparam bit OUT_REG_USED = 1'b1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // Enabled edges from address capture to data on the read pins.
  localparam logic [1:0] READ_LAT_CYCLES = 2'd2;

  // ----------------------------------------------------------------
  // Register map, byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;

  // Control fields and their values after reset.
  localparam int CTRL_ORCE_BIT = 0;
  localparam int CTRL_ORST_BIT = 1;
  localparam int CTRL_FREEZE_BIT = 2;
  localparam int CTRL_EXT_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : ram_ctrl_pkg

/* ram_pin_map.sv */
// Output flops for the memory pins and the packing of words onto both ports.
// Assumes the memory block samples these pins on the rising edge of clk_sys.
`timescale 1ns/10ps
module ram_pin_map
  import ram_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Next values from the sequencer and the control, address and data registers
  input wire logic [WADDR_W-1:0] word_addr_next,
  input wire logic [WORD_W-1:0] wdata_next,
  input wire logic ce_next,
  input wire logic we_next,
  input wire logic orce_next,
  input wire logic orst_next,
  input wire logic freeze_next,
  input wire logic [EXT_W-1:0] ext_next,
  // Memory pins
  output logic [PADDR_W-1:0] port_a_address,
  output logic [PADDR_W-1:0] port_b_address,
  output logic port_a_address_freeze,
  output logic port_b_address_freeze,
  output logic [PORT_W-1:0] port_a_write_data,
  output logic [PORT_W-1:0] port_b_write_data,
  output logic [EXT_W-1:0] port_a_depth_extension,
  output logic [EXT_W-1:0] port_b_depth_extension,
  output logic port_a_input_clock_enable,
  output logic port_b_input_clock_enable,
  output logic port_a_output_reg_enable,
  output logic port_b_output_reg_enable,
  output logic port_a_output_reg_reset,
  output logic port_b_output_reg_reset,
  output logic port_a_write_enable,
  output logic port_b_write_enable,
  input wire logic [PORT_W-1:0] port_a_read_data,
  input wire logic [PORT_W-1:0] port_b_read_data,
  // Assembled read word
  output logic [WORD_W-1:0] read_word
);

  // ----------------------------------------------------------------
  // Packing helpers
  // ----------------------------------------------------------------
  // Parity positions carry zero; nothing downstream uses them.
  function automatic logic [PORT_W-1:0] pack_half(input logic [HALF_W-1:0] h);
    pack_half = {1'b0, h[15:8], 1'b0, h[7:0]};
  endfunction : pack_half

  function automatic logic [HALF_W-1:0] unpack_half(input logic [PORT_W-1:0] p);
    unpack_half = {p[16:9], p[7:0]};
  endfunction : unpack_half

  // ----------------------------------------------------------------
  // Pin flops
  // ----------------------------------------------------------------
  logic [PADDR_W-1:0] paddr_next;
  assign paddr_next = {word_addr_next, PADDR_LOW_FILL};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_a_address <= {WADDR_W'(0), PADDR_LOW_FILL};
      port_b_address <= {WADDR_W'(0), PADDR_LOW_FILL};
      port_a_write_data <= '0;
      port_b_write_data <= '0;
    end else begin
      port_a_address <= paddr_next;
      port_b_address <= paddr_next;
      port_a_write_data <= pack_half(wdata_next[15:0]);
      port_b_write_data <= pack_half(wdata_next[31:16]);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_a_address_freeze <= 1'b0;
      port_b_address_freeze <= 1'b0;
      port_a_depth_extension <= EXT_UNUSED;
      port_b_depth_extension <= EXT_UNUSED;
    end else begin
      port_a_address_freeze <= freeze_next;
      port_b_address_freeze <= freeze_next;
      port_a_depth_extension <= ext_next;
      port_b_depth_extension <= ext_next;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      port_a_input_clock_enable <= 1'b0;
      port_b_input_clock_enable <= 1'b0;
      port_a_output_reg_enable <= 1'b0;
      port_b_output_reg_enable <= 1'b0;
      port_a_output_reg_reset <= 1'b0;
      port_b_output_reg_reset <= 1'b0;
      port_a_write_enable <= 1'b0;
      port_b_write_enable <= 1'b0;
    end else begin
      port_a_input_clock_enable <= ce_next;
      port_b_input_clock_enable <= ce_next;
      port_a_output_reg_enable <= orce_next;
      port_b_output_reg_enable <= orce_next;
      port_a_output_reg_reset <= orst_next;
      port_b_output_reg_reset <= orst_next;
      port_a_write_enable <= we_next;
      port_b_write_enable <= we_next;
    end
  end

  // Bits 8 and 17 of both read ports are deliberately left unread.
  assign read_word = {unpack_half(port_b_read_data), unpack_half(port_a_read_data)};

endmodule : ram_pin_map

/* testbench.sv */
// Self-checking bench for the memory controller and its AXI4-Lite port.
// Assumes the memory block model stands on the controller's pins.
`timescale 1ns/10ps
module testbench;
  import ram_ctrl_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic port_a_clock, port_b_clock, port_a_address_freeze, port_b_address_freeze;
  logic [PADDR_W-1:0] port_a_address, port_b_address;
  logic [PORT_W-1:0] port_a_write_data, port_b_write_data, port_a_read_data, port_b_read_data;
  logic [EXT_W-1:0] port_a_depth_extension, port_b_depth_extension;
  logic port_a_input_clock_enable, port_b_input_clock_enable;
  logic port_a_output_reg_enable, port_b_output_reg_enable;
  logic port_a_output_reg_reset, port_b_output_reg_reset;
  logic port_a_write_enable, port_b_write_enable;
  int miscompares = 0;
  int num_checks = 0;
  int we_cnt = 0;

  ram_ctrl dut (.clk_sys, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .port_a_clock, .port_b_clock, .port_a_address, .port_b_address,
    .port_a_address_freeze, .port_b_address_freeze, .port_a_write_data, .port_b_write_data,
    .port_a_depth_extension, .port_b_depth_extension, .port_a_input_clock_enable,
    .port_b_input_clock_enable, .port_a_output_reg_enable, .port_b_output_reg_enable,
    .port_a_output_reg_reset, .port_b_output_reg_reset, .port_a_write_enable,
    .port_b_write_enable, .port_a_read_data, .port_b_read_data);

  ram_block_model mem (.clk(port_a_clock), .addr(port_a_address),
    .ce(port_a_input_clock_enable), .we(port_a_write_enable), .orce(port_a_output_reg_enable),
    .orst(port_a_output_reg_reset), .wd_a(port_a_write_data), .wd_b(port_b_write_data),
    .rd_a(port_a_read_data), .rd_b(port_b_read_data));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_awready !== 1'b1 || s_axi_wready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wr_ok

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rd_chk

  // Polling is bounded so that a controller that never finishes shows up as a mismatch.
  task automatic mem_op(input logic [1:0] cmd, input logic [8:0] a, input logic [31:0] d);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    wr_ok(OFS_ADDR, {23'h0, a});
    wr_ok(OFS_WDATA, d);
    wr_ok(OFS_CMD, {30'h0, cmd});
    n = 0;
    s = '0;
    while (s[STAT_DONE_BIT] !== 1'b1 && n < 20) begin
      axi_rd(OFS_STATUS, s, r);
      n++;
    end
    check({30'h0, s[1:0]}, 32'h2);
    wr_ok(OFS_STATUS, 32'h2);
  endtask : mem_op

  always @(posedge clk_sys) begin
    if (port_a_write_enable === 1'b1) begin
      we_cnt <= we_cnt + 1;
    end
    if (nrst) begin
      check({9'h0, port_a_clock, port_a_address, port_a_address_freeze, port_a_depth_extension,
        port_a_input_clock_enable, port_a_output_reg_enable, port_a_output_reg_reset,
        port_a_write_enable}, {9'h0, port_b_clock, port_b_address, port_b_address_freeze,
        port_b_depth_extension, port_b_input_clock_enable, port_b_output_reg_enable,
        port_b_output_reg_reset, port_b_write_enable});
    end
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(OFS_CTRL, CTRL_RESET);
    rd_chk(OFS_STATUS, 32'h0);
    @(negedge clk_sys);
    check({18'h0, port_a_address}, {27'h0, PADDR_LOW_FILL});
    check({31'h0, port_a_address_freeze}, 32'h0);
    check({29'h0, port_a_depth_extension}, {29'h0, EXT_UNUSED});
    check({31'h0, port_a_output_reg_enable}, 32'h1);
    @(posedge clk_sys);
    $display("reset test done");
  endtask : t_reset

  task automatic t_write_read();
    logic [8:0] adr [3] = '{9'h000, 9'h1ff, 9'h0a5};
    logic [31:0] dat [3] = '{32'h1234_5678, 32'hfedc_ba98, 32'h00ff_ff00};
    int c;
    for (int i = 0; i < 3; i++) begin
      c = we_cnt;
      mem_op({i[0], 1'b1}, adr[i], dat[i]);
      check(we_cnt, c + 1);
      check({14'h0, port_a_write_data}, {15'h0, dat[i][15:8], 1'b0, dat[i][7:0]});
      check({14'h0, port_b_write_data}, {15'h0, dat[i][31:24], 1'b0, dat[i][23:16]});
      check({18'h0, port_b_address}, {18'h0, adr[i], 5'h1f});
    end
    for (int i = 0; i < 3; i++) begin
      mem_op(2'h2, adr[i], 32'h0);
      rd_chk(OFS_RDATA, dat[i]);
    end
    $display("write and read test done");
  endtask : t_write_read

  task automatic t_outreg();
    mem_op(2'h2, 9'h000, 32'h0);
    wr_ok(OFS_CTRL, 32'h0);
    mem_op(2'h2, 9'h1ff, 32'h0);
    rd_chk(OFS_RDATA, 32'h1234_5678);
    wr_ok(OFS_CTRL, 32'h2);
    @(negedge clk_sys);
    check({31'h0, port_b_output_reg_reset}, 32'h1);
    @(posedge clk_sys);
    mem_op(2'h2, 9'h1ff, 32'h0);
    rd_chk(OFS_RDATA, 32'h0);
    wr_ok(OFS_CTRL, CTRL_RESET);
    mem_op(2'h2, 9'h1ff, 32'h0);
    rd_chk(OFS_RDATA, 32'hfedc_ba98);
    $display("output register test done");
  endtask : t_outreg

  task automatic t_levels();
    logic [31:0] d;
    logic [1:0] r;
    wr_ok(OFS_CTRL, 32'h75);
    @(negedge clk_sys);
    check({30'h0, port_a_address_freeze, port_b_address_freeze}, 32'h3);
    check({29'h0, port_b_depth_extension}, 32'h7);
    @(posedge clk_sys);
    rd_chk(OFS_CTRL, 32'h75);
    wr_ok(OFS_CTRL, CTRL_RESET);
    axi_wr(8'h18, 32'h1, r);
    check({30'h0, r}, {30'h0, RESP_DECERR});
    axi_rd(8'h02, d, r);
    check({d[29:0], r}, {30'h0, RESP_DECERR});
    $display("level and unmapped test done");
  endtask : t_levels

  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_write_read();
    t_outreg();
    t_levels();
    report_and_stop();
  end

  // All scenarios take a few hundred cycles; this span leaves ample margin.
  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end
endmodule : testbench
